// >>> core/cpwm_pkg.sv
package cpwm_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;     // 100 MHz clock
    localparam int unsigned CARRIER_NS    = 10000;  // 100 kHz carrier
    localparam int unsigned UPDATE_NS     = 50000;  // Update spacing
    // Center mode: up ARR cycles, down ARR cycles per carrier period
    localparam logic [15:0] PERIOD_RELOAD_VALUE =
        16'(CARRIER_NS / (2 * CLK_PERIOD_NS));
    localparam int unsigned REP_PERIODS = UPDATE_NS / CARRIER_NS;
    localparam logic [2:0]  REP_RELOAD  = 3'(REP_PERIODS - 1);

    // ---------------------------------------------------------------
    // Strings and converter
    // ---------------------------------------------------------------
    localparam int unsigned NUM_STRINGS = 4;
    localparam int unsigned ADC_W       = 10;
    localparam logic [2:0]  SLOT_LAST   = 3'h3;  // Last string slot
    localparam logic [2:0]  SLOT_AUX    = 3'h4;  // Extra sense slot
    localparam logic [3:0]  MUX_FIRST   = 4'h8;  // string_sense_input_a
    localparam logic [3:0]  MUX_AUX     = 4'hc;  // string_sense_input_e

    // ---------------------------------------------------------------
    // Regulator
    // ---------------------------------------------------------------
    localparam logic [15:0] DUTY_MIN    = 16'h0010;
    localparam logic [15:0] DUTY_MAX    = 16'h01c2;
    localparam logic [15:0] DUTY_RESET  = 16'h0064;
    localparam int unsigned PROP_SHIFT  = 4;
    localparam int unsigned INTEG_SHIFT = 8;
    localparam int unsigned INTEG_W     = 24;

    typedef enum logic [1:0] {
        CPWM_UP     = 2'h0,
        CPWM_DOWN   = 2'h1,
        CPWM_CENTER = 2'h2
    } cpwm_mode_t;

    typedef enum logic [3:0] {
        CPWM_IDLE  = 4'h1,
        CPWM_WAIT  = 4'h2,
        CPWM_CALC  = 4'h4,
        CPWM_WRITE = 4'h8
    } cpwm_state_t;

endpackage

// >>> core/cpwm_core.sv
`timescale 1ns/1ns
// Functional notes
// - Center mode counts 0 up to reload-1, then raises overflow.
// - Then counts reload down to 1, underflow, restarts from zero.
// - 16-bit counter with up, down and up/down modes, auto reload.
// - Four channels, each with true and complementary PWM outputs.
// - Each channel's compare value sets its duty on the carrier.
// - Overflow or underflow selectable as converter trigger source.
// - Crest overflow makes the update; sample lands mid on-time.
// - Carrier runs at 100 kHz, 10 us period, in center mode.
// - Update issued once per five carrier periods, every 50 us in center mode.
// - End of conversion updates measured string's compare value.
// - After update, next string selected; round robin over four.
// - One regulation step per update; all strings every 200 us in center mode with the aux slot off.
// - PI regulator per string, integral frozen while pushing into a limit.
// - Trigger output driven by update: one start pulse per update.
// - Sense inputs a..e converted one per update event.
module cpwm_core
(
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     arst_n_in,
    // Timer configuration
    input  wire cpwm_pkg::cpwm_mode_t     count_mode_in,
    input  wire logic                     trig_src_unf_in,
    input  wire logic                     one_pulse_in,
    input  wire logic                     aux_slot_en_in,
    // Regulator settings
    input  wire logic [9:0]               reference_in,
    input  wire logic [7:0]               kp_in,
    input  wire logic [7:0]               ki_in,
    // Converter answer pins
    input  wire logic                     adc_eoc_in,
    input  wire logic [9:0]               adc_data_in,
    // Power switches
    output logic [3:0]                    pwm_out,
    output logic [3:0]                    pwm_n_out,
    // Converter control
    output logic                          timer_trigger_out,
    output logic [3:0]                    adc_chan_out,
    output logic [9:0]                    aux_result_out
);
    import cpwm_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [15:0]        cnt,  next_cnt;
    logic               dir,  next_dir;     // 1 while counting down
    logic               run,  next_run;
    logic [2:0]         rep,  next_rep;
    logic               ovf, unf, prd_end, sel_evt, upd;
    logic [15:0]        cmp_act    [NUM_STRINGS];
    logic [15:0]        next_act   [NUM_STRINGS];
    logic [15:0]        cmp_shadow [NUM_STRINGS];
    logic [15:0]        next_shad  [NUM_STRINGS];
    logic signed [INTEG_W-1:0] integ      [NUM_STRINGS];
    logic signed [INTEG_W-1:0] next_integ [NUM_STRINGS];
    logic [3:0]         sat_hi, next_sat_hi, sat_lo, next_sat_lo;
    logic [3:0]         next_pwm;
    logic               next_trig;
    logic [3:0]         next_chan;
    logic [9:0]         next_aux;
    cpwm_state_t        state, next_state;
    logic [2:0]         slot, next_slot;
    logic [9:0]         meas, next_meas;
    logic signed [19:0] prop, next_prop, iterm, next_iterm;
    logic               eoc_s1, eoc_s2, eoc_s3;
    logic [9:0]         data_s1, data_s2;
    logic               eoc_rise;
    logic signed [24:0] duty_calc;

    // ---------------------------------------------------------------
    // Carrier counter
    // ---------------------------------------------------------------
    // Counter and repetition next values
    always_comb
    begin
        next_cnt = cnt;
        next_dir = dir;
        next_run = run;
        next_rep = rep;
        ovf      = 1'b0;
        unf      = 1'b0;
        if (run)
        begin
            case (count_mode_in)
                CPWM_UP:
                begin
                    ovf      = (cnt >= PERIOD_RELOAD_VALUE);
                    next_cnt = ovf ? 16'h0000 : cnt + 16'h0001;
                    next_dir = 1'b0;
                end
                CPWM_DOWN:
                begin
                    unf      = (cnt == 16'h0000);
                    next_cnt = unf ? PERIOD_RELOAD_VALUE : cnt - 16'h0001;
                    next_dir = 1'b1;
                end
                default:
                begin
                    if (!dir && cnt >= PERIOD_RELOAD_VALUE - 16'h0001)
                    begin
                        ovf      = 1'b1;
                        next_cnt = PERIOD_RELOAD_VALUE;
                        next_dir = 1'b1;
                    end
                    else if (dir && cnt <= 16'h0001)
                    begin
                        unf      = 1'b1;
                        next_cnt = 16'h0000;
                        next_dir = 1'b0;
                    end
                    else
                    begin
                        next_cnt = dir ? cnt - 16'h0001 : cnt + 16'h0001;
                    end
                end
            endcase
        end
        // Period ends at overflow in up mode, else at the valley, where PWM is off at the swap
        prd_end = (count_mode_in == CPWM_UP) ? ovf : unf;
        // Crest by default puts the sample mid on-time
        sel_evt = trig_src_unf_in ? unf : ovf;
        upd     = sel_evt && (rep == 3'h0);
        if (sel_evt)
            next_rep = (rep == 3'h0) ? REP_RELOAD : rep - 3'h1;
        // One-pulse stops at period end, resumes once released
        if (prd_end && one_pulse_in)
            next_run = 1'b0;
        else if (!one_pulse_in)
            next_run = 1'b1;
    end

    // Counter registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt <= 16'h0000;
            dir <= 1'b0;
            run <= 1'b1;
            rep <= REP_RELOAD;
        end
        else
        begin
            cnt <= next_cnt;
            dir <= next_dir;
            run <= next_run;
            rep <= next_rep;
        end
    end

    // ---------------------------------------------------------------
    // Channels
    // ---------------------------------------------------------------
    // Compare preload and pulse shaping
    always_comb
    begin
        for (int i = 0; i < NUM_STRINGS; i++)
        begin
            // Swap only at period end: no clipped pulse
            next_act[i] = prd_end ? cmp_shadow[i] : cmp_act[i];
            // In center mode on-time centred on the crest, width set by compare
            next_pwm[i] = ({1'b0, cnt} + {1'b0, cmp_act[i]}) >
                          {1'b0, PERIOD_RELOAD_VALUE};
        end
        next_trig = upd;
    end

    // Channel registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            for (int i = 0; i < NUM_STRINGS; i++)
                cmp_act[i] <= DUTY_RESET;
            pwm_out           <= 4'h0;
            pwm_n_out         <= 4'hf;
            timer_trigger_out <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_STRINGS; i++)
                cmp_act[i] <= next_act[i];
            pwm_out           <= next_pwm;
            pwm_n_out         <= ~next_pwm;
            timer_trigger_out <= next_trig;
        end
    end

    // ---------------------------------------------------------------
    // Converter answer synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            eoc_s1  <= 1'b0;
            eoc_s2  <= 1'b0;
            eoc_s3  <= 1'b0;
            data_s1 <= 10'h000;
            data_s2 <= 10'h000;
        end
        else
        begin
            eoc_s1  <= adc_eoc_in;
            eoc_s2  <= eoc_s1;
            eoc_s3  <= eoc_s2;
            data_s1 <= adc_data_in;
            data_s2 <= data_s1;
        end
    end
    assign eoc_rise = eoc_s2 && !eoc_s3;

    // ---------------------------------------------------------------
    // Sequencer and PI regulator
    // ---------------------------------------------------------------
    // Updates arriving mid-step are skipped, never queued
    always_comb
    begin
        logic signed [10:0] err;
        logic signed [24:0] sum;
        logic               freeze;
        err         = $signed({1'b0, reference_in}) - $signed({1'b0, meas});
        sum         = 25'sh0;
        freeze      = 1'b0;
        duty_calc   = 25'sh0;
        next_state  = state;
        next_slot   = slot;
        next_meas   = meas;
        next_prop   = prop;
        next_iterm  = iterm;
        next_aux    = aux_result_out;
        next_sat_hi = sat_hi;
        next_sat_lo = sat_lo;
        for (int i = 0; i < NUM_STRINGS; i++)
        begin
            next_shad[i]  = cmp_shadow[i];
            next_integ[i] = integ[i];
        end
        next_chan = (slot == SLOT_AUX) ? MUX_AUX
                                       : MUX_FIRST + {1'b0, slot};
        case (state)
            CPWM_IDLE:
                if (upd)
                    next_state = CPWM_WAIT;
            CPWM_WAIT:
                if (eoc_rise)
                begin
                    next_meas  = data_s2;
                    next_state = CPWM_CALC;
                end
            CPWM_CALC:
            begin
                next_prop  = $signed({1'b0, kp_in}) * err;
                next_iterm = $signed({1'b0, ki_in}) * err;
                next_state = CPWM_WRITE;
            end
            CPWM_WRITE:
            begin
                next_state = CPWM_IDLE;
                if (slot == SLOT_AUX)
                begin
                    next_aux  = meas;
                    next_slot = 3'h0;
                end
                else
                begin
                    // Integral frozen while pushing into a limit
                    freeze = (sat_hi[slot[1:0]] && iterm > 0) ||
                             (sat_lo[slot[1:0]] && iterm < 0);
                    sum = 25'(integ[slot[1:0]]) + 25'(iterm);
                    if (!freeze)
                    begin
                        if (sum[24] != sum[23])
                            next_integ[slot[1:0]] = sum[24]
                                ? {1'b1, {(INTEG_W-1){1'b0}}}
                                : {1'b0, {(INTEG_W-1){1'b1}}};
                        else
                            next_integ[slot[1:0]] = sum[23:0];
                    end
                    duty_calc = 25'(prop >>> PROP_SHIFT) +
                        25'(next_integ[slot[1:0]] >>> INTEG_SHIFT);
                    next_sat_hi[slot[1:0]] =
                        duty_calc >= $signed({9'h000, DUTY_MAX});
                    next_sat_lo[slot[1:0]] =
                        duty_calc <= $signed({9'h000, DUTY_MIN});
                    if (next_sat_hi[slot[1:0]])
                        next_shad[slot[1:0]] = DUTY_MAX;
                    else if (next_sat_lo[slot[1:0]])
                        next_shad[slot[1:0]] = DUTY_MIN;
                    else
                        next_shad[slot[1:0]] = duty_calc[15:0];
                    if (slot == SLOT_LAST)
                        next_slot = aux_slot_en_in ? SLOT_AUX : 3'h0;
                    else
                        next_slot = slot + 3'h1;
                end
            end
            default:
                next_state = CPWM_IDLE;
        endcase
    end

    // Regulator registers
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state          <= CPWM_IDLE;
            slot           <= 3'h0;
            meas           <= 10'h000;
            prop           <= 20'sh0;
            iterm          <= 20'sh0;
            sat_hi         <= 4'h0;
            sat_lo         <= 4'h0;
            adc_chan_out   <= MUX_FIRST;
            aux_result_out <= 10'h000;
            for (int i = 0; i < NUM_STRINGS; i++)
            begin
                cmp_shadow[i] <= DUTY_RESET;
                integ[i]      <= '0;
            end
        end
        else
        begin
            state          <= next_state;
            slot           <= next_slot;
            meas           <= next_meas;
            prop           <= next_prop;
            iterm          <= next_iterm;
            sat_hi         <= next_sat_hi;
            sat_lo         <= next_sat_lo;
            adc_chan_out   <= next_chan;
            aux_result_out <= next_aux;
            for (int i = 0; i < NUM_STRINGS; i++)
            begin
                cmp_shadow[i] <= next_shad[i];
                integ[i]      <= next_integ[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Shortest legal spacing is the up/down-only carrier of reload+1
    localparam logic [15:0] MIN_GAP =
        16'(REP_PERIODS * (int'(PERIOD_RELOAD_VALUE) + 1) - 1);
    logic [15:0] gap;
    logic        seen;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            gap  <= 16'h0000;
            seen <= 1'b0;
        end
        else
        begin
            gap  <= timer_trigger_out ? 16'h0000 : gap + 16'h0001;
            seen <= seen | timer_trigger_out;
        end
    end

    AST_CREST: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (count_mode_in == CPWM_CENTER && run && !dir &&
         cnt == PERIOD_RELOAD_VALUE - 16'h0001)
        |=> (cnt == PERIOD_RELOAD_VALUE && dir))
        else $error("crest not reached after reload-1");
    AST_VALLEY: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (count_mode_in == CPWM_CENTER && run && dir && cnt == 16'h0001)
        |=> (cnt == 16'h0000 && !dir))
        else $error("valley restart wrong");
    AST_RANGE: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        cnt <= PERIOD_RELOAD_VALUE)
        else $error("counter above reload");
    AST_TRIG_PULSE: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        upd |=> timer_trigger_out ##1 !timer_trigger_out)
        else $error("trigger not one pulse per update");
    AST_GAP: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (timer_trigger_out && seen) |-> gap >= MIN_GAP)
        else $error("updates closer than five periods");
    AST_CHAN_HOLD: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (state == CPWM_WAIT && $past(state) == CPWM_WAIT)
        |-> $stable(adc_chan_out))
        else $error("channel moved during conversion");
    AST_NEXT_STRING: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (state == CPWM_WRITE && slot < SLOT_LAST)
        |=> slot == $past(slot) + 3'h1)
        else $error("sequencer did not advance");
    AST_DUTY_LIMIT: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (state == CPWM_WRITE && slot != SLOT_AUX) |=>
        (cmp_shadow[$past(slot[1:0])] >= DUTY_MIN &&
         cmp_shadow[$past(slot[1:0])] <= DUTY_MAX))
        else $error("duty outside limits");
    AST_PRELOAD: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        !prd_end |=> cmp_act[0] == $past(cmp_act[0]))
        else $error("compare changed mid period");
    AST_EOC_STEP: assert property (
        @(posedge clk_in) disable iff (!arst_n_in)
        (state == CPWM_WAIT && eoc_rise) |=> state == CPWM_CALC ##1
        state == CPWM_WRITE ##1 state == CPWM_IDLE)
        else $error("regulation step not completed");

    COV_UPDATE: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        timer_trigger_out);
    COV_WRAP: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        state == CPWM_WRITE && slot == SLOT_LAST);
    COV_SAT: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        |sat_hi);
endmodule

// >>> tb/cpwm_adc_model.sv
`timescale 1ns/1ns
// ------------------------------------------
// Converter stand-in, one shot per start
// ------------------------------------------
module cpwm_adc_model
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // Start pulse and analog level
    input  wire logic       start_in,
    input  wire logic [9:0] meas_in,
    input  wire logic [9:0] delay_in,
    // Result pins
    output logic            eoc_out,
    output logic [9:0]      data_out
);
    logic       busy;
    logic [9:0] cnt;

    // Starts while busy are lost; the data lines toggle when not valid
    // so a stale result can never be mistaken for a fresh one
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy     <= 1'b0;
            cnt      <= 10'h000;
            eoc_out  <= 1'b0;
            data_out <= 10'h155;
        end
        else if (start_in && !busy)
        begin
            busy     <= 1'b1;
            cnt      <= delay_in + 10'h005;
            data_out <= ~data_out;
        end
        else if (busy)
        begin
            cnt     <= cnt - 10'h001;
            eoc_out <= (cnt <= 10'h005) && (cnt > 10'h001);
            busy    <= (cnt != 10'h001);
            if (cnt == 10'h005)
                data_out <= meas_in;
            else if ((cnt > 10'h005) || (cnt == 10'h001))
                data_out <= ~data_out;
        end
        else
            data_out <= ~data_out;
    end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
    import cpwm_pkg::*;
    // ------------------------------------------
    // Stimulus, clock and counters
    // ------------------------------------------
    logic       clk_in    = 1'b0;
    logic       arst_n_in = 1'b0;
    cpwm_mode_t mode      = CPWM_CENTER;
    logic       unf       = 1'b0;
    logic       aux       = 1'b0;
    logic       one_p     = 1'b0;
    logic [9:0] ref_v     = 10'h3ff;
    logic [9:0] meas      = 10'h000;
    logic [9:0] dly       = 10'h028;
    logic [7:0] kp        = 8'h00;
    logic [7:0] ki        = 8'hff;
    logic       eoc;
    logic       trig;
    logic [9:0] adata;
    logic [9:0] aux_res;
    logic [3:0] pwm;
    logic [3:0] pwm_n;
    logic [3:0] chan;
    int         failures    = 0;
    int         checks_done = 0;
    int         gap_c = 2 * int'(REP_PERIODS) * int'(PERIOD_RELOAD_VALUE);
    int         gap_u = int'(REP_PERIODS) * (int'(PERIOD_RELOAD_VALUE) + 1);

    always #5 clk_in = ~clk_in;

    cpwm_core cpwm_core_i
    (
        .clk_in            (clk_in),
        .arst_n_in         (arst_n_in),
        .count_mode_in     (mode),
        .trig_src_unf_in   (unf),
        .one_pulse_in      (one_p),
        .aux_slot_en_in    (aux),
        .reference_in      (ref_v),
        .kp_in             (kp),
        .ki_in             (ki),
        .adc_eoc_in        (eoc),
        .adc_data_in       (adata),
        .pwm_out           (pwm),
        .pwm_n_out         (pwm_n),
        .timer_trigger_out (trig),
        .adc_chan_out      (chan),
        .aux_result_out    (aux_res)
    );

    cpwm_adc_model cpwm_adc_model_i
    (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .start_in  (trig),
        .meas_in   (meas),
        .delay_in  (dly),
        .eoc_out   (eoc),
        .data_out  (adata)
    );

    // ------------------------------------------
    // Shared helpers
    // ------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic report_and_stop;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded wait for the converter start pulse
    task automatic wait_trig(output int n);
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end while (trig !== 1'b1 && n < 6000);
        if (n >= 6000)
        begin
            failures++;
            report_and_stop;
        end
    endtask

    // Reset with new settings; outputs are judged while reset is held
    task automatic restart(input cpwm_mode_t m, input logic u, input logic a);
        arst_n_in <= 1'b0;
        mode      <= m;
        unf       <= u;
        aux       <= a;
        repeat (16) @(posedge clk_in);
        chk(16'(pwm), 16'h0000);
        chk(16'(pwm_n), 16'h000f);
        chk(16'(trig), 16'h0000);
        chk(16'(chan), 16'h0008);
        arst_n_in <= 1'b1;
        $display("test reset done");
    endtask

    // High cycles of one string over one carrier period
    task automatic duty_chk(input int i, input int hi);
        int   c  = 0;
        logic ok = 1'b1;
        repeat (1000)
        begin
            @(posedge clk_in);
            c += int'(pwm[i]);
            // Exact match also trips on unknown switch levels
            if ((pwm ^ pwm_n) !== 4'hf)
                ok = 1'b0;
        end
        chk(16'(c), 16'(hi));
        chk(16'(ok), 16'h0001);
        $display("test duty done");
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    // Drive string 0 into saturation, then reverse the error: without
    // anti-windup the duty would stay at its ceiling
    task automatic t_pi;
        int n;
        dly <= 10'd340;
        for (int k = 0; k < 9; k++)
        begin
            if (k == 8)
            begin
                ref_v <= 10'h000;
                meas  <= 10'h3ff;
            end
            wait_trig(n);
            chk(16'(chan), 16'(8 + k % 4));
            chk(16'(pwm[chan[1:0]]), 16'h0001);
            if (k != 0 && k != 6)
                chk(16'(n), 16'(gap_c));
            if (k == 5)
                duty_chk(0, 2 * int'(DUTY_MAX) - 1);
        end
        repeat (2000) @(posedge clk_in);
        duty_chk(0, 2 * int'(DUTY_MIN) - 1);
        $display("test regulator done");
    endtask

    task automatic t_gap(input int gap);
        int n;
        wait_trig(n);
        wait_trig(n);
        chk(16'(n), 16'(gap));
        $display("test spacing done");
    endtask

    // One-pulse: carrier parks at the valley after one period, so
    // switches stay off; releasing it brings the reset duty back
    task automatic t_one;
        one_p <= 1'b1;
        repeat (1100) @(posedge clk_in);
        duty_chk(0, 0);
        one_p <= 1'b0;
        duty_chk(1, 2 * int'(DUTY_RESET) - 1);
        $display("test one-pulse done");
    endtask

    // Fifth slot: sense input e follows string 3, result kept aside
    task automatic t_aux;
        int n;
        meas <= 10'h2a5;
        dly  <= 10'd40;
        for (int k = 0; k < 5; k++)
        begin
            wait_trig(n);
            chk(16'(chan), 16'(8 + k));
        end
        repeat (80) @(posedge clk_in);
        chk(16'(aux_res), 16'h02a5);
        $display("test aux done");
    endtask

    initial
    begin
        restart(CPWM_CENTER, 1'b0, 1'b0);
        duty_chk(3, 2 * int'(DUTY_RESET) - 1);
        t_pi;
        restart(CPWM_CENTER, 1'b1, 1'b0);
        t_gap(gap_c);
        restart(CPWM_UP, 1'b0, 1'b0);
        t_gap(gap_u);
        restart(CPWM_DOWN, 1'b1, 1'b0);
        t_gap(gap_u);
        restart(CPWM_CENTER, 1'b0, 1'b0);
        t_one;
        restart(CPWM_UP, 1'b0, 1'b1);
        t_aux;
        report_and_stop;
    end
endmodule
